/* File: logic/bit_shift_flag_unit.sv */
// Bit, bit-test, shift and stack execution unit with its own status flags
module bit_shift_flag_unit #(
   parameter int DATA_W      = 8,
   parameter int STACK_DEPTH = 16
) (
   input  wire logic                      clk_sys,
   input  wire logic                      rst_n,
   input  wire logic                      start,
   input  wire bit_shift_pkg::request_type req,
   output bit_shift_pkg::result_type       dest_result,
   output bit_shift_pkg::result_type       io_result,
   output logic [7:0]                      status_flags,
   output logic                            busy,
   output logic                            done
);
   localparam int PTR_W = $clog2(STACK_DEPTH);

   bit_shift_pkg::stack_state_type state_reg;
   bit_shift_pkg::stack_state_type state_next;
   logic [DATA_W-1:0]              stack_mem [STACK_DEPTH];
   logic [PTR_W-1:0]               ptr_reg;
   logic [7:0]                     status_flags_reg;
   logic [7:0]                     flags_next;
   bit_shift_pkg::result_type      dest_reg;
   bit_shift_pkg::result_type      dest_next;
   bit_shift_pkg::result_type      io_reg;
   bit_shift_pkg::result_type      io_next;
   logic                           done_reg;
   logic                           done_next;
   logic                           busy_reg;
   logic [DATA_W-1:0]              shift_result;
   logic                           sh_c;
   logic                           sh_z;
   logic                           sh_n;
   logic                           sh_v;
   logic [7:0]                     sel_mask;
   logic                           accept;
   logic                           is_shift;
   logic                           is_push;
   logic                           is_pop;
   logic [PTR_W-1:0]               pop_ptr;

   shift_core #(
      .DATA_W (DATA_W)
   ) u_shift_core (
      .op           (req.op),
      .value        (req.dest_operand),
      .carry_in     (status_flags_reg[bit_shift_pkg::FLAG_C_POS]),
      .transfer_in  (status_flags_reg[bit_shift_pkg::FLAG_T_POS]),
      .bit_sel      (req.bit_sel),
      .result       (shift_result),
      .carry_out    (sh_c),
      .zero_out     (sh_z),
      .negative_out (sh_n),
      .overflow_out (sh_v)
   );

   // New work is taken only while the stack sequencer is idle
   assign accept   = start && (state_reg == bit_shift_pkg::idle_state);
   assign sel_mask = 8'h01 << req.bit_sel;
   assign is_push  = accept && (req.op == bit_shift_pkg::stack_push_op);
   assign is_pop   = accept && (req.op == bit_shift_pkg::stack_pop_op);
   assign is_shift = (req.op == bit_shift_pkg::logic_shift_up_op)
                  || (req.op == bit_shift_pkg::logic_shift_down_op)
                  || (req.op == bit_shift_pkg::rotate_up_carry_op)
                  || (req.op == bit_shift_pkg::rotate_down_carry_op)
                  || (req.op == bit_shift_pkg::signed_shift_down_op);
   assign pop_ptr  = ptr_reg + 1'b1;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         bit_shift_pkg::idle_state: begin
            if (is_push) begin
               state_next = bit_shift_pkg::push_state;
            end else if (is_pop) begin
               state_next = bit_shift_pkg::pop_state;
            end
         end
         default: begin
            state_next = bit_shift_pkg::idle_state;
         end
      endcase
   end

   always_comb begin
      flags_next = status_flags_reg;
      dest_next  = '0;
      io_next    = '0;
      done_next  = 1'b0;
      if (state_reg == bit_shift_pkg::pop_state) begin
         dest_next = '{valid: 1'b1, data: stack_mem[ptr_reg]};
         done_next = 1'b1;
      end else if (state_reg == bit_shift_pkg::push_state) begin
         done_next = 1'b1;
      end else if (accept && !is_push && !is_pop && req.op != bit_shift_pkg::nop_op) begin
         done_next = 1'b1;
         if (is_shift) begin
            dest_next = '{valid: 1'b1, data: shift_result};
            flags_next[bit_shift_pkg::FLAG_C_POS] = sh_c;
            flags_next[bit_shift_pkg::FLAG_Z_POS] = sh_z;
            flags_next[bit_shift_pkg::FLAG_N_POS] = sh_n;
            flags_next[bit_shift_pkg::FLAG_V_POS] = sh_v;
            flags_next[bit_shift_pkg::FLAG_S_POS] = sh_n ^ sh_v;
         end
         case (req.op)
            bit_shift_pkg::io_bit_force_high_op: io_next = '{valid: 1'b1, data: req.io_value | sel_mask};
            bit_shift_pkg::io_bit_force_low_op:  io_next = '{valid: 1'b1, data: req.io_value & ~sel_mask};
            bit_shift_pkg::nibble_swap_op:       dest_next = '{valid: 1'b1, data: shift_result};
            bit_shift_pkg::transfer_to_bit_op:   dest_next = '{valid: 1'b1, data: shift_result};
            bit_shift_pkg::flag_force_high_op:   flags_next = status_flags_reg | sel_mask;
            bit_shift_pkg::flag_force_low_op:    flags_next = status_flags_reg & ~sel_mask;
            bit_shift_pkg::bit_to_transfer_op:
               flags_next[bit_shift_pkg::FLAG_T_POS] = req.source_operand[req.bit_sel];
            bit_shift_pkg::carry_force_high_op:  flags_next[bit_shift_pkg::FLAG_C_POS] = 1'b1;
            bit_shift_pkg::carry_force_low_op:   flags_next[bit_shift_pkg::FLAG_C_POS] = 1'b0;
            bit_shift_pkg::negative_force_high_op: flags_next[bit_shift_pkg::FLAG_N_POS] = 1'b1;
            bit_shift_pkg::negative_force_low_op:  flags_next[bit_shift_pkg::FLAG_N_POS] = 1'b0;
            bit_shift_pkg::zero_force_high_op:   flags_next[bit_shift_pkg::FLAG_Z_POS] = 1'b1;
            bit_shift_pkg::zero_force_low_op:    flags_next[bit_shift_pkg::FLAG_Z_POS] = 1'b0;
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_reg        <= bit_shift_pkg::idle_state;
         status_flags_reg <= bit_shift_pkg::FLAGS_RESET;
         dest_reg         <= '0;
         io_reg           <= '0;
         done_reg         <= 1'b0;
         busy_reg         <= 1'b0;
      end else begin
         // Busy is registered from the next state so the port comes straight from a flip-flop
         busy_reg         <= (state_next != bit_shift_pkg::idle_state);
         state_reg        <= state_next;
         status_flags_reg <= flags_next;
         dest_reg         <= dest_next;
         io_reg           <= io_next;
         done_reg         <= done_next;
      end
   end

   // Stack grows downward; pointer names the next free slot, wraps silently when full
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ptr_reg <= PTR_W'(STACK_DEPTH - 1);
      end else if (is_push) begin
         ptr_reg <= ptr_reg - 1'b1;
      end else if (is_pop) begin
         ptr_reg <= pop_ptr;
      end
   end

   // Storage has no reset, like a real stack memory
   always_ff @(posedge clk_sys) begin
      if (is_push) begin
         stack_mem[ptr_reg] <= req.source_operand;
      end
   end

   assign dest_result  = dest_reg;
   assign io_result    = io_reg;
   assign status_flags = status_flags_reg;
   assign busy         = busy_reg;
   assign done         = done_reg;
endmodule : bit_shift_flag_unit

/* File: include/bit_shift_pkg.sv */
// Package with operation codes, flag positions and carriers for the bit and shift unit
package bit_shift_pkg;
   localparam int DATA_W = 8;
   localparam int SEL_W  = 3;

   // Status flag bit positions
   localparam logic [2:0] FLAG_C_POS = 3'h0;
   localparam logic [2:0] FLAG_Z_POS = 3'h1;
   localparam logic [2:0] FLAG_N_POS = 3'h2;
   localparam logic [2:0] FLAG_V_POS = 3'h3;
   localparam logic [2:0] FLAG_S_POS = 3'h4;
   localparam logic [2:0] FLAG_T_POS = 3'h6;

   localparam logic [7:0] FLAGS_RESET   = 8'h00;
   localparam logic [7:0] DATA_RESET    = 8'h00;
   localparam logic [7:0] SP_RESET      = 8'hFF;
   localparam int         STACK_CYCLES  = 2;

   typedef enum logic [4:0] {
      nop_op                 = 5'h00,
      stack_push_op          = 5'h01,
      stack_pop_op           = 5'h02,
      io_bit_force_high_op   = 5'h03,
      io_bit_force_low_op    = 5'h04,
      logic_shift_up_op      = 5'h05,
      logic_shift_down_op    = 5'h06,
      rotate_up_carry_op     = 5'h07,
      rotate_down_carry_op   = 5'h08,
      signed_shift_down_op   = 5'h09,
      nibble_swap_op         = 5'h0A,
      flag_force_high_op     = 5'h0B,
      flag_force_low_op      = 5'h0C,
      bit_to_transfer_op     = 5'h0D,
      transfer_to_bit_op     = 5'h0E,
      carry_force_high_op    = 5'h0F,
      carry_force_low_op     = 5'h10,
      negative_force_high_op = 5'h11,
      negative_force_low_op  = 5'h12,
      zero_force_high_op     = 5'h13,
      zero_force_low_op      = 5'h14
   } op_type;

   typedef enum logic [1:0] {
      idle_state = 2'b00,
      push_state = 2'b01,
      pop_state  = 2'b10
   } stack_state_type;

   typedef struct packed {
      op_type          op;
      logic [7:0]      dest_operand;
      logic [7:0]      source_operand;
      logic [2:0]      bit_sel;
      logic [7:0]      io_value;
   } request_type;

   typedef struct packed {
      logic            valid;
      logic [7:0]      data;
   } result_type;
endpackage : bit_shift_pkg

/* File: logic/shift_core.sv */
// Combinational shift, rotate, swap and bit-insert data path with flag results
module shift_core #(
   parameter int DATA_W = 8
) (
   input  wire logic [4:0]        op,
   input  wire logic [DATA_W-1:0] value,
   input  wire logic              carry_in,
   input  wire logic              transfer_in,
   input  wire logic [2:0]        bit_sel,
   output logic      [DATA_W-1:0] result,
   output logic                   carry_out,
   output logic                   zero_out,
   output logic                   negative_out,
   output logic                   overflow_out
);
   logic [DATA_W-1:0] bit_mask;
   logic              carry_sel;

   assign bit_mask = {{(DATA_W-1){1'b0}}, 1'b1} << bit_sel;

   always_comb begin
      result    = value;
      carry_sel = carry_in;
      case (bit_shift_pkg::op_type'(op))
         bit_shift_pkg::logic_shift_up_op: begin
            result    = {value[DATA_W-2:0], 1'b0};
            carry_sel = value[DATA_W-1];
         end
         bit_shift_pkg::logic_shift_down_op: begin
            result    = {1'b0, value[DATA_W-1:1]};
            carry_sel = value[0];
         end
         bit_shift_pkg::rotate_up_carry_op: begin
            result    = {value[DATA_W-2:0], carry_in};
            carry_sel = value[DATA_W-1];
         end
         bit_shift_pkg::rotate_down_carry_op: begin
            result    = {carry_in, value[DATA_W-1:1]};
            carry_sel = value[0];
         end
         bit_shift_pkg::signed_shift_down_op: begin
            result    = {value[DATA_W-1], value[DATA_W-1:1]};
            carry_sel = value[0];
         end
         bit_shift_pkg::nibble_swap_op: begin
            result = {value[DATA_W/2-1:0], value[DATA_W-1:DATA_W/2]};
         end
         bit_shift_pkg::transfer_to_bit_op: begin
            result = transfer_in ? (value | bit_mask) : (value & ~bit_mask);
         end
         default: begin
            result    = value;
            carry_sel = carry_in;
         end
      endcase
   end

   assign carry_out    = carry_sel;
   assign zero_out     = (result == '0);
   assign negative_out = result[DATA_W-1];
   // Overflow is N xor C after the shift, as for every shift of this family
   assign overflow_out = result[DATA_W-1] ^ carry_sel;
endmodule : shift_core

/* File: dv/io_file_model.sv */
// Behavioural model of the core I/O register file on the far side of the unit
module io_file_model (
   input  wire logic                      clk_sys,
   input  wire logic                      rst_n,
   input  wire logic [2:0]                io_sel,
   input  wire bit_shift_pkg::result_type io_result,
   output logic      [7:0]                io_value
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] io_mem_reg [8];
   logic [2:0] wr_sel_reg;
   // Pending write is forwarded, since the result lands one edge after it is shown
   assign io_value = (io_result.valid && wr_sel_reg == io_sel) ? io_result.data : io_mem_reg[io_sel];
   // Write back only on the valid pulse, to the register addressed when the request was taken
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         io_mem_reg <= '{default: 8'h00};
         wr_sel_reg <= 3'h0;
      end else begin
         wr_sel_reg <= io_sel;
         if (io_result.valid) begin
            io_mem_reg[wr_sel_reg] <= io_result.data;
         end
      end
   end
endmodule : io_file_model

/* File: dv/bit_shift_flag_unit_properties.sv */
// Concurrent checks on the ports of the bit, shift and flag unit
module bit_shift_flag_unit_checker #(
   parameter int DATA_W      = 8,
   parameter int STACK_DEPTH = 16
) (
   input wire logic                       clk_sys,
   input wire logic                       rst_n,
   input wire logic                       start,
   input wire bit_shift_pkg::request_type req,
   input wire bit_shift_pkg::result_type  dest_result,
   input wire bit_shift_pkg::result_type  io_result,
   input wire logic [7:0]                 status_flags,
   input wire logic                       busy,
   input wire logic                       done
);
   timeunit 1ns;
   timeprecision 1ps;
   logic take;
   logic stack_op;
   assign take     = start & ~busy;
   assign stack_op = req.op inside {bit_shift_pkg::stack_push_op, bit_shift_pkg::stack_pop_op};
   default clocking dflt_cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   AST_ONE_CYCLE: assert property (take && !stack_op && req.op != bit_shift_pkg::nop_op |=> done && !busy)
      else $error("single cycle operation did not finish in one cycle");
   AST_STACK_TWO: assert property (take && stack_op |=> busy && !done ##1 done && !busy)
      else $error("stack operation did not take two cycles");
   AST_STACK_FLAGS: assert property (take && stack_op |=> $stable(status_flags) [*2])
      else $error("stack operation changed flags");
   AST_POP_VALID: assert property (take && req.op == bit_shift_pkg::stack_pop_op |=> !dest_result.valid ##1 dest_result.valid)
      else $error("pop result not on second cycle");
   AST_IO_HIGH: assert property (take && req.op == bit_shift_pkg::io_bit_force_high_op |=> io_result.valid && io_result.data == ($past(req.io_value) | (8'h01 << $past(req.bit_sel))))
      else $error("io bit set result wrong");
   AST_IO_LOW: assert property (take && req.op == bit_shift_pkg::io_bit_force_low_op |=> io_result.valid && io_result.data == ($past(req.io_value) & ~(8'h01 << $past(req.bit_sel))))
      else $error("io bit clear result wrong");
   AST_SHIFT_UP: assert property (take && req.op == bit_shift_pkg::logic_shift_up_op |=> dest_result.data == {$past(req.dest_operand[6:0]), 1'b0} && status_flags[0] == $past(req.dest_operand[7]))
      else $error("shift up result or carry wrong");
   AST_SWAP: assert property (take && req.op == bit_shift_pkg::nibble_swap_op |=> dest_result.data == {$past(req.dest_operand[3:0]), $past(req.dest_operand[7:4])} && $stable(status_flags))
      else $error("nibble swap wrong");
   AST_ZERO_HIGH: assert property (take && req.op == bit_shift_pkg::zero_force_high_op |=> status_flags == ($past(status_flags) | 8'h02))
      else $error("zero set touched wrong flags");
   AST_ZERO_LOW: assert property (take && req.op == bit_shift_pkg::zero_force_low_op |=> status_flags == ($past(status_flags) & 8'hFD))
      else $error("zero clear touched wrong flags");
endmodule : bit_shift_flag_unit_checker

bind bit_shift_flag_unit bit_shift_flag_unit_checker #(.DATA_W(DATA_W), .STACK_DEPTH(STACK_DEPTH)) checker_u (
   .clk_sys(clk_sys), .rst_n(rst_n), .start(start), .req(req), .dest_result(dest_result),
   .io_result(io_result), .status_flags(status_flags), .busy(busy), .done(done)
);

/* File: dv/bit_shift_flag_unit_tb.sv */
// Self-checking bench for the bit, shift and flag unit
module bit_shift_flag_unit_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic                       clk_sys = 1'b0;
   logic                       rst_n = 1'b0;
   logic                       start = 1'b0;
   bit_shift_pkg::request_type req = '0;
   bit_shift_pkg::result_type  dest_result;
   bit_shift_pkg::result_type  io_result;
   logic [7:0]                 status_flags;
   logic                       busy;
   logic                       done;
   logic [2:0]                 io_sel = 3'h0;
   logic [7:0]                 io_value;
   logic [7:0]                 mf = 8'h00;
   logic [7:0]                 mio [8] = '{default: 8'h00};
   logic [7:0]                 q [$];
   logic [31:0]                seed = 32'h000183EA;
   int                         error_cnt = 0;
   int                         check_count = 0;
   int                         cyc = 0;
   always #20 clk_sys = ~clk_sys;
   bit_shift_flag_unit #(.DATA_W(8), .STACK_DEPTH(16)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .start(start),
      .req(req), .dest_result(dest_result), .io_result(io_result), .status_flags(status_flags), .busy(busy), .done(done));
   io_file_model io_u (.clk_sys(clk_sys), .rst_n(rst_n), .io_sel(io_sel), .io_result(io_result), .io_value(io_value));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_sim
   // Start is left high between calls, so a held request during busy must be ignored
   task automatic run(input bit_shift_pkg::op_type o, input logic [7:0] d, s, input logic [2:0] b, p);
      logic [7:0] r;
      logic [7:0] ei;
      logic       c;
      logic       dv;
      logic       iv;
      int         n;
      chk(io_value, mio[io_sel]);
      io_sel = p;
      start = 1'b1;
      req = '{o, d, s, b, mio[p]};
      r = d;
      c = mf[0];
      ei = mio[p];
      n = 0;
      case (o)
         bit_shift_pkg::stack_push_op:          q.push_back(s);
         bit_shift_pkg::stack_pop_op:           r = q.pop_back();
         bit_shift_pkg::io_bit_force_high_op:   ei[b] = 1'b1;
         bit_shift_pkg::io_bit_force_low_op:    ei[b] = 1'b0;
         bit_shift_pkg::logic_shift_up_op:      {c, r} = {d, 1'b0};
         bit_shift_pkg::logic_shift_down_op:    {r, c} = {1'b0, d};
         bit_shift_pkg::rotate_up_carry_op:     {c, r} = {d, mf[0]};
         bit_shift_pkg::rotate_down_carry_op:   {r, c} = {mf[0], d};
         bit_shift_pkg::signed_shift_down_op:   {r, c} = {d[7], d};
         bit_shift_pkg::nibble_swap_op:         r = {d[3:0], d[7:4]};
         bit_shift_pkg::flag_force_high_op:     mf[b] = 1'b1;
         bit_shift_pkg::flag_force_low_op:      mf[b] = 1'b0;
         bit_shift_pkg::bit_to_transfer_op:     mf[6] = s[b];
         bit_shift_pkg::transfer_to_bit_op:     r[b] = mf[6];
         bit_shift_pkg::carry_force_high_op:    mf[0] = 1'b1;
         bit_shift_pkg::carry_force_low_op:     mf[0] = 1'b0;
         bit_shift_pkg::negative_force_high_op: mf[2] = 1'b1;
         bit_shift_pkg::negative_force_low_op:  mf[2] = 1'b0;
         bit_shift_pkg::zero_force_high_op:     mf[1] = 1'b1;
         bit_shift_pkg::zero_force_low_op:      mf[1] = 1'b0;
         default:                               r = d;
      endcase
      if (o inside {[bit_shift_pkg::logic_shift_up_op : bit_shift_pkg::signed_shift_down_op]}) begin
         mf[4:0] = {c, r[7] ^ c, r[7], r == 8'h00, c};
      end
      dv = o inside {[bit_shift_pkg::logic_shift_up_op : bit_shift_pkg::nibble_swap_op],
                     bit_shift_pkg::stack_pop_op, bit_shift_pkg::transfer_to_bit_op};
      iv = o inside {bit_shift_pkg::io_bit_force_high_op, bit_shift_pkg::io_bit_force_low_op};
      do begin
         @(negedge clk_sys);
         n++;
      end while (done !== 1'b1 && n < 6);
      chk(8'(n), (o inside {bit_shift_pkg::stack_push_op, bit_shift_pkg::stack_pop_op}) ?
          8'(bit_shift_pkg::STACK_CYCLES) : 8'h01);
      chk(8'(dest_result.valid), 8'(dv));
      if (dv) chk(dest_result.data, r);
      chk(8'(io_result.valid), 8'(iv));
      if (iv) chk(io_result.data, ei);
      chk(status_flags, mf);
      if (iv) mio[p] = ei;
   endtask : run
   // Cycle ceiling well above the roughly 900 cycles the sequence needs
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         end_sim();
      end
   end
   initial begin
      repeat (5) @(negedge clk_sys);
      rst_n = 1'b1;
      run(bit_shift_pkg::stack_push_op, 8'h00, 8'hA5, 3'h0, 3'h0);
      run(bit_shift_pkg::stack_push_op, 8'h00, 8'h3C, 3'h0, 3'h0);
      run(bit_shift_pkg::stack_pop_op, 8'h00, 8'h00, 3'h0, 3'h0);
      run(bit_shift_pkg::stack_pop_op, 8'h00, 8'h00, 3'h0, 3'h0);
      run(bit_shift_pkg::logic_shift_up_op, 8'h80, 8'h00, 3'h0, 3'h0);
      run(bit_shift_pkg::logic_shift_down_op, 8'h01, 8'h00, 3'h0, 3'h0);
      run(bit_shift_pkg::rotate_up_carry_op, 8'h80, 8'h00, 3'h0, 3'h0);
      run(bit_shift_pkg::rotate_down_carry_op, 8'h01, 8'h00, 3'h0, 3'h0);
      run(bit_shift_pkg::signed_shift_down_op, 8'h81, 8'h00, 3'h0, 3'h0);
      run(bit_shift_pkg::io_bit_force_high_op, 8'h00, 8'h00, 3'h7, 3'h2);
      run(bit_shift_pkg::io_bit_force_low_op, 8'h00, 8'h00, 3'h7, 3'h2);
      for (int k = 0; k < 40; k++) begin
         for (int i = 1; i < 21; i++) begin
            seed = lfsr(seed);
            run(bit_shift_pkg::op_type'(i[4:0]), seed[7:0], seed[15:8], seed[18:16], seed[21:19]);
         end
      end
      start = 1'b0;
      end_sim();
   end
endmodule : bit_shift_flag_unit_tb
